/* File: logic/ucs_chan_cmd.sv */
// two-channel command decode and status tracking with chan b clock select
// assumes a synchronous host port and external bit-time ticks per channel
//
// Operation
// - chan b rx clock: 1110 pin two 16x, 1111 pin two 1x.
// - chan b tx clock: 1110 pin five 16x, 1111 pin five 1x.
// - one command write may hold several non-conflicting commands.
// - field 000 does nothing; 001 points mode pointer at first register.
// - field 010 resets receiver: disabled, fifo emptied.
// - field 011 resets the transmitter to its reset state.
// - 100 clears status bits 7..4; 101 clears change-of-break.
// - 110 starts break after queued characters, only when tx enabled; a character in the holding register is not sent and stalls the break.
// - 111 ends break; line high one bit before next character.
// - bit 3 disables tx after draining; bit 2 enables, sets ready.
// - bit 1 stops receiver at once; multidrop keeps receiving.
// - bit 0 enables receiver, start search unless wake-up mode.
// - enable together with disable performs the disable.
// - channel b command and status behave as channel a.
// - break flags one fifo entry, blocks more until line marks.
// - break start and break end both set change-of-break.
// - status bit 6 is the per-character missing stop bit.
// - bit 5 parity error, or address flag in multidrop.
// - bit 4 overrun; waiting character lost; error reset or receiver reset clears.
// - tx empty sets on enable and underrun, clears on load/disable.
// - tx ready clears on load, sets on transfer and enable.
// - fifo full at three entries, stays set while a char waits.
// - rx ready while fifo holds characters.
// - baud codes use shared table; 1101 timer; rate-set bit passes.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ucs_chan_cmd #(
  parameter int unsigned ADDR_W = ucs_pkg::ADDR_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [7:0] o_rdata,
  input wire ucs_pkg::ucs_rx_s [1:0] i_rx,
  input wire logic [1:0] i_rx_mark,
  input wire logic [1:0] i_bit_tick,
  input wire logic [1:0] i_multidrop,
  input wire logic [1:0] i_wakeup,
  input wire logic [1:0] i_parity_on,
  input wire logic [1:0] i_mr_access,
  input wire logic i_rate_set,
  output logic [1:0] o_serial_out,
  output logic [1:0] o_rx_run,
  output logic [1:0] o_rx_hunt,
  output logic [1:0] o_rx_abort,
  output logic [1:0] o_mr_first,
  output ucs_pkg::ucs_clk_s o_b_rx_clk,
  output ucs_pkg::ucs_clk_s o_b_tx_clk
);
  import ucs_pkg::*;

  initial begin
    if (ADDR_W < 3) begin
      $error("ADDR_W too small for the register map");
    end
  end

  ucs_state_s q, n;
  logic [1:0] wr_cmd, wr_thr, rd_rhr;
  logic [7:0] a_stat;

  function automatic logic [7:0] stat(input ucs_chan_s s);
    stat = {s.fifo[0][10:8], s.ovr, s.tx_emt, s.tx_rdy,
      s.cnt == FIFO_DEPTH, s.cnt != 2'h0};
  endfunction

  function automatic ucs_clk_s clk_dec(input logic [3:0] code,
      input logic rs);
    clk_dec.code = code;
    clk_dec.rate_set = rs;
    clk_dec.x16 = (code != CS_PIN_1X);
    case (code)
      CS_TIMER: clk_dec.src = CLK_TIMER;
      CS_PIN_16X: clk_dec.src = CLK_PIN_16X;
      CS_PIN_1X: clk_dec.src = CLK_PIN_1X;
      default: clk_dec.src = CLK_BRG;
    endcase
  endfunction

  function automatic ucs_chan_s chan_rst();
    chan_rst = '0;
    chan_rst.ser = 1'b1;
    chan_rst.mr_first = 1'b1;
    chan_rst.brk = BRK_IDLE;
  endfunction

  always_comb begin
    wr_cmd[0] = i_we && (i_addr == ADDR_W'(OFS_A_CMD));
    wr_cmd[1] = i_we && (i_addr == ADDR_W'(OFS_B_CMD));
    wr_thr[0] = i_we && (i_addr == ADDR_W'(OFS_A_HOLD));
    wr_thr[1] = i_we && (i_addr == ADDR_W'(OFS_B_HOLD));
    rd_rhr[0] = i_re && (i_addr == ADDR_W'(OFS_A_HOLD));
    rd_rhr[1] = i_re && (i_addr == ADDR_W'(OFS_B_HOLD));
  end

  always_comb begin
    ucs_chan_s s;
    logic [10:0] ent;
    s = '0;
    ent = '0;
    n = q;
    n.rdata = 8'h00;
    if (i_we && (i_addr == ADDR_W'(OFS_B_CLK))) begin
      n.csr_b = i_wdata;
    end
    for (int c = 0; c < 2; c++) begin
      s = q.ch[c];
      s.hunt = 1'b0;
      s.abort = 1'b0;
      // host read pops the head, waiting char drops in behind
      if (rd_rhr[c] && s.cnt != 2'h0) begin
        s.fifo[0] = s.fifo[1];
        s.fifo[1] = s.fifo[2];
        s.fifo[2] = '0;
        s.cnt = s.cnt - 2'h1;
        if (s.rx_wait) begin
          s.fifo[s.cnt] = s.rsr;
          s.cnt = s.cnt + 2'h1;
          s.rx_wait = 1'b0;
        end
      end
      if (i_mr_access[c]) begin
        s.mr_first = 1'b0;
      end
      if (wr_cmd[c]) begin
        case (i_wdata[6:4])
          CMD_NONE: s.mr_first = s.mr_first;
          CMD_MR_PTR: s.mr_first = 1'b1;
          CMD_RX_RST: begin
            s.rx_en = 1'b0;
            s.cnt = 2'h0;
            s.rx_wait = 1'b0;
            s.ovr = 1'b0;
            s.brk_blk = 1'b0;
            s.fifo = '0;
          end
          CMD_TX_RST: begin
            s.tx_en = 1'b0;
            s.tx_pend = 1'b0;
            s.tx_rdy = 1'b0;
            s.tx_emt = 1'b0;
            s.thr_full = 1'b0;
            s.tbits = 4'h0;
            s.ser = 1'b1;
            s.brk = BRK_IDLE;
          end
          CMD_ERR_RST: begin
            s.ovr = 1'b0;
            for (int i = 0; i < 3; i++) begin
              s.fifo[i][10:8] = 3'h0;
            end
          end
          CMD_BRK_CLR: s.isr_brk = 1'b0;
          CMD_BRK_GO: begin
            if (s.tx_en && s.brk == BRK_IDLE) begin
              s.brk = BRK_WAIT;
            end
          end
          CMD_BRK_END: begin
            if (s.brk == BRK_WAIT) begin
              s.brk = BRK_IDLE;
            end else if (s.brk == BRK_ON) begin
              s.brk = BRK_GUARD;
            end
          end
          default: s.brk = s.brk;
        endcase
        // disable is tested first so it wins over a paired enable
        if (i_wdata[CB_TX_DIS]) begin
          s.tx_pend = (s.tx_en || s.tx_pend) &&
            (s.thr_full || s.tbits != 4'h0);
          s.tx_en = 1'b0;
          s.tx_rdy = 1'b0;
          s.tx_emt = 1'b0;
        end else if (i_wdata[CB_TX_EN]) begin
          s.tx_en = 1'b1;
          s.tx_pend = 1'b0;
          s.tx_rdy = !s.thr_full;
          s.tx_emt = !s.thr_full && s.tbits == 4'h0;
        end
        if (i_wdata[CB_RX_DIS]) begin
          s.rx_en = 1'b0;
          s.abort = 1'b1;
        end else if (i_wdata[CB_RX_EN]) begin
          s.rx_en = 1'b1;
          s.hunt = !i_wakeup[c];
        end
      end
      // receive side; multidrop receives even while disabled
      if (i_rx[c].valid && (s.rx_en || i_multidrop[c]) &&
          !s.brk_blk) begin
        ent = {i_rx[c].brk, i_rx[c].fe,
          i_multidrop[c] ? i_rx[c].ad : (i_parity_on[c] && i_rx[c].pe),
          i_rx[c].data};
        if (i_rx[c].brk) begin
          s.brk_blk = 1'b1;
          s.isr_brk = 1'b1;
        end
        if (s.cnt != FIFO_DEPTH) begin
          s.fifo[s.cnt] = ent;
          s.cnt = s.cnt + 2'h1;
        end else if (s.rx_wait) begin
          s.rsr = ent;
          s.ovr = 1'b1;
        end else begin
          s.rsr = ent;
          s.rx_wait = 1'b1;
        end
      end
      if (i_rx_mark[c] && s.brk_blk) begin
        s.brk_blk = 1'b0;
        s.isr_brk = 1'b1;
      end
      // loads while disabled are dropped and never sent
      if (wr_thr[c] && s.tx_en) begin
        s.tx_holding_reg = i_wdata;
        s.thr_full = 1'b1;
        s.tx_rdy = 1'b0;
        s.tx_emt = 1'b0;
      end
      if (i_bit_tick[c]) begin
        if (s.brk == BRK_ON) begin
          s.ser = 1'b0;
        end else if (s.tbits != 4'h0) begin
          s.ser = s.tsr[0];
          s.tsr = {1'b1, s.tsr[9:1]};
          s.tbits = s.tbits - 4'h1;
        end else begin
          s.ser = 1'b1;
          if (s.brk == BRK_GUARD) begin
            s.brk = BRK_IDLE;
          end else if (s.brk == BRK_WAIT && !s.thr_full) begin
            s.brk = BRK_ON;
            s.ser = 1'b0;
          end else if (s.thr_full && s.brk == BRK_IDLE) begin
            s.tsr = {1'b1, s.tx_holding_reg, 1'b0};
            s.tbits = TX_FRAME;
            s.thr_full = 1'b0;
            s.tx_rdy = s.tx_en;
          end else if (!s.thr_full && s.tx_pend) begin
            s.tx_pend = 1'b0;
          end else if (!s.thr_full && s.tx_en) begin
            s.tx_emt = 1'b1;
          end
        end
      end
      n.ch[c] = s;
    end
    if (i_re) begin
      case (i_addr)
        ADDR_W'(OFS_A_CMD): n.rdata = stat(q.ch[0]);
        ADDR_W'(OFS_A_HOLD): n.rdata = q.ch[0].fifo[0][7:0];
        ADDR_W'(OFS_B_CMD): n.rdata = stat(q.ch[1]);
        ADDR_W'(OFS_B_HOLD): n.rdata = q.ch[1].fifo[0][7:0];
        ADDR_W'(OFS_B_CLK): n.rdata = q.csr_b;
        ADDR_W'(OFS_ISR): begin
          n.rdata = 8'h00;
          n.rdata[ISR_A_BRK] = q.ch[0].isr_brk;
          n.rdata[ISR_B_BRK] = q.ch[1].isr_brk;
        end
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      q <= '{ch: '{chan_rst(), chan_rst()}, csr_b: 8'h00, rdata: 8'h00};
    end else if (i_ce) begin
      q <= n;
    end
  end

  always_comb begin
    o_rdata = q.rdata;
    a_stat = stat(q.ch[0]);
    for (int c = 0; c < 2; c++) begin
      o_serial_out[c] = q.ch[c].ser;
      o_rx_run[c] = q.ch[c].rx_en || i_multidrop[c];
      o_rx_hunt[c] = q.ch[c].hunt;
      o_rx_abort[c] = q.ch[c].abort;
      o_mr_first[c] = q.ch[c].mr_first;
    end
    o_b_rx_clk = clk_dec(q.csr_b[7:4], i_rate_set);
    o_b_tx_clk = clk_dec(q.csr_b[3:0], i_rate_set);
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b || !i_ce);

  sequence cmd_a(logic [7:0] m, logic [7:0] v);
    i_we && i_addr == ADDR_W'(OFS_A_CMD) && (i_wdata & m) == v;
  endsequence

  // end-of-break tick with no command racing it
  sequence guard_tick;
    q.ch[0].brk == BRK_GUARD && i_bit_tick[0] && !wr_cmd[0];
  endsequence

  sequence wait_tick;
    q.ch[0].brk == BRK_WAIT && i_bit_tick[0] && q.ch[0].tbits == 4'h0 &&
      !q.ch[0].thr_full && !wr_cmd[0] && !wr_thr[0];
  endsequence

  disable_wins_a: assert property (
    cmd_a(8'h0C, 8'h0C) |=> !q.ch[0].tx_en && !q.ch[0].tx_rdy)
    else $error("tx enable won over disable");
  err_reset_a: assert property (
    cmd_a(8'h70, 8'h40) ##0 !i_rx[0].valid |=> a_stat[7:4] == 4'h0)
    else $error("error reset left status bits");
  brk_needs_en_a: assert property (
    cmd_a(8'h70, 8'h60) ##0 (!q.ch[0].tx_en && q.ch[0].brk == BRK_IDLE)
    |=> q.ch[0].brk == BRK_IDLE)
    else $error("break accepted with transmitter disabled");
  brk_line_low_a: assert property (
    q.ch[0].brk == BRK_ON && i_bit_tick[0] && !wr_cmd[0]
    |=> !o_serial_out[0])
    else $error("line not spacing during break");
  rx_ready_clr_a: assert property (
    rd_rhr[0] && q.ch[0].cnt == 2'h1 && !q.ch[0].rx_wait &&
    !i_rx[0].valid |=> !a_stat[0])
    else $error("rx ready stayed set on empty fifo");
  full_stays_a: assert property (
    rd_rhr[0] && q.ch[0].cnt == FIFO_DEPTH && q.ch[0].rx_wait
    |=> a_stat[1] ##1 a_stat[1] || $fell(q.ch[0].cnt[0]))
    else $error("fifo full dropped with char waiting");
  overrun_set_a: assert property (
    i_rx[0].valid && q.ch[0].rx_en && !q.ch[0].brk_blk &&
    q.ch[0].cnt == FIFO_DEPTH && q.ch[0].rx_wait && !rd_rhr[0] &&
    !i_we |=> q.ch[0].ovr)
    else $error("overrun not flagged");
  thr_load_a: assert property (
    wr_thr[0] && q.ch[0].tx_en && !i_bit_tick[0]
    |=> !q.ch[0].tx_emt && q.ch[0].thr_full)
    else $error("holding load left tx empty set");
  clk_one_x_a: assert property (
    q.csr_b[7:4] == CS_PIN_1X |-> !o_b_rx_clk.x16 &&
    o_b_rx_clk.src == CLK_PIN_1X)
    else $error("rx 1x clock not selected");
  brk_isr_a: assert property (
    i_rx[1].valid && i_rx[1].brk && q.ch[1].rx_en && !q.ch[1].brk_blk
    |=> q.ch[1].isr_brk && q.ch[1].brk_blk)
    else $error("break did not set change bit");
  brk_start_a: assert property (
    wait_tick |=> q.ch[0].brk == BRK_ON && !o_serial_out[0])
    else $error("break did not start from idle transmitter");
  brk_guard_a: assert property (
    guard_tick |=> o_serial_out[0] && q.ch[0].brk == BRK_IDLE)
    else $error("line not marking after break end");
  hunt_pulse_a: assert property (
    cmd_a(8'h03, 8'h01) ##0 !i_wakeup[0] |=> o_rx_hunt[0] && q.ch[0].rx_en)
    else $error("rx enable did not start search");
  abort_pulse_a: assert property (
    cmd_a(8'h02, 8'h02) |=> o_rx_abort[0] && !q.ch[0].rx_en)
    else $error("rx disable did not abort");
  mr_ptr_a: assert property (
    cmd_a(8'h70, 8'h10) |=> o_mr_first[0])
    else $error("mode pointer not at first register");
  rx_reset_a: assert property (
    cmd_a(8'h71, 8'h20) ##0 !i_rx[0].valid
    |=> q.ch[0].cnt == 2'h0 && !q.ch[0].rx_en)
    else $error("receiver reset left fifo or enable");
  tx_reset_a: assert property (
    cmd_a(8'h7C, 8'h30) |=> !q.ch[0].tx_en && !q.ch[0].thr_full &&
    o_serial_out[0] && q.ch[0].brk == BRK_IDLE)
    else $error("transmitter reset incomplete");
  tx_ready_en_a: assert property (
    cmd_a(8'h0C, 8'h04) ##0 !q.ch[0].thr_full |=> q.ch[0].tx_rdy)
    else $error("tx enable did not set ready");
  rx_block_a: assert property (
    q.ch[0].brk_blk && !i_rx_mark[0] && !wr_cmd[0] && !rd_rhr[0]
    |=> $stable(q.ch[0].cnt))
    else $error("fifo entry taken during break block");
endmodule

/* File: logic/ucs_pkg.sv */
// constants, register map and carrier types for the channel command block
// assumes one device clock; receive shifting and sampling live outside
package ucs_pkg;
  localparam int unsigned ADDR_W = 3;
  // register offsets (index on the plain register port)
  localparam logic [2:0] OFS_A_CMD = 3'h0; // write command, read status
  localparam logic [2:0] OFS_A_HOLD = 3'h1; // write tx hold, read rx hold
  localparam logic [2:0] OFS_B_CMD = 3'h2;
  localparam logic [2:0] OFS_B_HOLD = 3'h3;
  localparam logic [2:0] OFS_B_CLK = 3'h4; // chan_b_clock_select
  localparam logic [2:0] OFS_ISR = 3'h5; // interrupt_status, read only
  // miscellaneous command field codes
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_MR_PTR = 3'h1;
  localparam logic [2:0] CMD_RX_RST = 3'h2;
  localparam logic [2:0] CMD_TX_RST = 3'h3;
  localparam logic [2:0] CMD_ERR_RST = 3'h4;
  localparam logic [2:0] CMD_BRK_CLR = 3'h5;
  localparam logic [2:0] CMD_BRK_GO = 3'h6;
  localparam logic [2:0] CMD_BRK_END = 3'h7;
  // command bit positions
  localparam int unsigned CB_TX_DIS = 3;
  localparam int unsigned CB_TX_EN = 2;
  localparam int unsigned CB_RX_DIS = 1;
  localparam int unsigned CB_RX_EN = 0;
  // interrupt status bit positions
  localparam int unsigned ISR_A_BRK = 2;
  localparam int unsigned ISR_B_BRK = 6;
  // clock select codes
  localparam logic [3:0] CS_TIMER = 4'hD;
  localparam logic [3:0] CS_PIN_16X = 4'hE;
  localparam logic [3:0] CS_PIN_1X = 4'hF;
  // receive fifo positions and transmit frame length
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  localparam logic [3:0] TX_FRAME = 4'hA;

  typedef enum logic [1:0] {
    CLK_BRG = 2'h0,
    CLK_TIMER = 2'h1,
    CLK_PIN_16X = 2'h2,
    CLK_PIN_1X = 2'h3
  } ucs_clk_src_e;

  typedef enum logic [3:0] {
    BRK_IDLE = 4'h1,
    BRK_WAIT = 4'h2,
    BRK_ON = 4'h4,
    BRK_GUARD = 4'h8
  } ucs_brk_e;

  typedef struct packed {
    ucs_clk_src_e src;
    logic x16;
    logic rate_set;
    logic [3:0] code;
  } ucs_clk_s;

  // one character handed over by the receive shifter
  typedef struct packed {
    logic valid;
    logic brk;
    logic fe;
    logic pe;
    logic ad;
    logic [7:0] data;
  } ucs_rx_s;

  typedef struct packed {
    logic rx_en;
    logic rx_wait;
    logic ovr;
    logic brk_blk;
    logic isr_brk;
    logic mr_first;
    logic hunt;
    logic abort;
    logic tx_en;
    logic tx_pend;
    logic tx_rdy;
    logic tx_emt;
    logic thr_full;
    logic ser;
    ucs_brk_e brk;
    logic [7:0] tx_holding_reg;
    logic [10:0] rsr;
    logic [1:0] cnt;
    logic [2:0][10:0] fifo;
    logic [9:0] tsr;
    logic [3:0] tbits;
  } ucs_chan_s;

  typedef struct packed {
    ucs_chan_s [1:0] ch;
    logic [7:0] csr_b;
    logic [7:0] rdata;
  } ucs_state_s;
endpackage

/* File: tb/ucs_chan_cmd_tb_top.sv */
// self-checking bench for the channel command and status block
// assumes the far model supplies bit ticks and watches chan a line
`timescale 1ns/1ps
module ucs_chan_cmd_tb_top;
  import ucs_pkg::*;
  // three crystal edges at 3.6864 MHz, in 8 ns clocks, rounded up plus one spare clock
  localparam int CMD_GAP = 52;
  logic mclk, rst_b, ce, we, re, rate_set, got;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, fbyte;
  ucs_rx_s [1:0] rx;
  logic [1:0] rx_mark, tick, mdrop, wake, par, mra;
  logic [1:0] ser, run, hunt, abort, mrf;
  ucs_clk_s brx, btx;
  int miscompares, comparisons, cycles;

  ucs_chan_cmd ucs_chan_cmd_inst (.i_mclk(mclk), .i_rst_b(rst_b), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata),
    .i_rx(rx), .i_rx_mark(rx_mark), .i_bit_tick(tick), .i_multidrop(mdrop),
    .i_wakeup(wake), .i_parity_on(par), .i_mr_access(mra),
    .i_rate_set(rate_set), .o_serial_out(ser), .o_rx_run(run),
    .o_rx_hunt(hunt), .o_rx_abort(abort), .o_mr_first(mrf),
    .o_b_rx_clk(brx), .o_b_tx_clk(btx));
  ucs_far_model ucs_far_model_inst (.i_mclk(mclk), .i_rst_b(rst_b),
    .i_line(ser[0]), .o_tick(tick), .o_byte(fbyte), .o_got(got));

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge mclk);
    we <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk);
    re <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // upper command bits need spacing, so every command waits first
  task automatic cmd(input logic [2:0] a, input logic [7:0] d);
    repeat (CMD_GAP) @(posedge mclk);
    wr(a, {1'b0, d[6:0]});
  endtask
  task automatic rxc(input int ch, input logic b, f, p, input logic [7:0] d);
    @(posedge mclk);
    rx[ch] <= {1'b1, b, f, p, 1'b0, d};
    @(posedge mclk);
    rx[ch].valid <= 1'b0;
  endtask
  task automatic wait_got(input int lim, output logic g);
    int n;
    n = 0;
    g = 1'b0;
    while (n < lim) begin
      @(posedge mclk);
      #1;
      if (got === 1'b1) g = 1'b1;
      n++;
    end
  endtask
  function automatic ucs_clk_s exp_clk(input logic [3:0] c, input logic rs);
    ucs_clk_s e;
    e.src = (c == 4'hD) ? CLK_TIMER : (c == 4'hE) ? CLK_PIN_16X :
      (c == 4'hF) ? CLK_PIN_1X : CLK_BRG;
    e.x16 = (c != 4'hF);
    e.rate_set = rs;
    e.code = c;
    return e;
  endfunction

  task automatic t_reset();
    chk(ser, 2'h3);
    chk(mrf, 2'h3);
    chk(run, 2'h0);
    rchk(OFS_A_CMD, 8'h00);
    rchk(OFS_ISR, 8'h00);
  endtask
  task automatic t_clk();
    logic [3:0] cs[4] = '{4'h0, 4'hD, 4'hE, 4'hF};
    for (int i = 0; i < 4; i++) begin
      rate_set <= i[0];
      wr(OFS_B_CLK, {cs[i], cs[3 - i]});
      chk(brx, exp_clk(cs[i], i[0]));
      chk(btx, exp_clk(cs[3 - i], i[0]));
    end
  endtask
  task automatic t_enable();
    cmd(OFS_A_CMD, 8'h05);
    chk(hunt, 2'h1);
    @(posedge mclk);
    #1;
    chk(hunt, 2'h0);
    rchk(OFS_A_CMD, 8'h0C);
    cmd(OFS_A_CMD, 8'h0F);
    chk(abort, 2'h1);
    chk(run, 2'h0);
    rchk(OFS_A_CMD, 8'h00);
    wake <= 2'h1;
    cmd(OFS_A_CMD, 8'h05);
    chk(hunt, 2'h0);
    wake <= 2'h0;
    mdrop <= 2'h1;
    cmd(OFS_A_CMD, 8'h02);
    chk(run, 2'h1);
    mdrop <= 2'h0;
    cmd(OFS_A_CMD, 8'h01);
    chk(run, 2'h1);
  endtask
  task automatic t_fifo();
    logic [7:0] exp[4] = '{8'h41, 8'h42, 8'h43, 8'h45};
    par <= 2'h1;
    for (int i = 0; i < 5; i++) rxc(0, 0, 0, i == 0, 8'(8'h41 + i));
    rchk(OFS_A_CMD, 8'h3F);
    cmd(OFS_A_CMD, 8'h40);
    rchk(OFS_A_CMD, 8'h0F);
    rchk(OFS_A_HOLD, exp[0]);
    rchk(OFS_A_CMD, 8'h0F);
    rchk(OFS_A_HOLD, exp[1]);
    rchk(OFS_A_CMD, 8'h0D);
    rchk(OFS_A_HOLD, exp[2]);
    rchk(OFS_A_HOLD, exp[3]);
    rchk(OFS_A_CMD, 8'h0C);
  endtask
  task automatic t_break();
    rxc(0, 1, 1, 0, 8'h00);
    rchk(OFS_A_CMD, 8'hCD);
    rchk(OFS_ISR, 8'h04);
    cmd(OFS_A_CMD, 8'h50);
    rchk(OFS_ISR, 8'h00);
    rxc(0, 0, 0, 0, 8'h55);
    rchk(OFS_A_HOLD, 8'h00);
    rchk(OFS_A_CMD, 8'h0C);
    @(posedge mclk);
    rx_mark <= 2'h1;
    @(posedge mclk);
    rx_mark <= 2'h0;
    rchk(OFS_ISR, 8'h04);
    rxc(0, 0, 0, 0, 8'h55);
    rchk(OFS_A_HOLD, 8'h55);
  endtask
  task automatic t_misc();
    @(posedge mclk);
    mra <= 2'h1;
    @(posedge mclk);
    mra <= 2'h0;
    @(posedge mclk);
    #1;
    chk(mrf, 2'h2);
    cmd(OFS_A_CMD, 8'h10);
    chk(mrf, 2'h3);
    rxc(0, 0, 0, 0, 8'h66);
    cmd(OFS_A_CMD, 8'h00);
    rchk(OFS_A_CMD, 8'h0D);
    cmd(OFS_A_CMD, 8'h20);
    rchk(OFS_A_CMD, 8'h0C);
    chk(run, 2'h0);
    cmd(OFS_B_CMD, 8'h05);
    rxc(1, 0, 0, 0, 8'h77);
    rchk(OFS_B_CMD, 8'h0D);
    rchk(OFS_A_CMD, 8'h0C);
    rchk(OFS_B_HOLD, 8'h77);
    rxc(1, 1, 0, 0, 8'h00);
    rchk(OFS_ISR, 8'h44);
  endtask
  task automatic t_tx();
    logic g;
    @(posedge mclk iff tick[0]);
    wr(OFS_A_HOLD, 8'hA5);
    rchk(OFS_A_CMD, 8'h00);
    cmd(OFS_A_CMD, 8'h08);
    wait_got(300, g);
    chk({g, fbyte}, {1'b1, 8'hA5});
    rchk(OFS_A_CMD, 8'h00);
    wr(OFS_A_HOLD, 8'h5A);
    cmd(OFS_A_CMD, 8'h04);
    rchk(OFS_A_CMD, 8'h0C);
    wait_got(300, g);
    chk(g, 1'b0);
    cmd(OFS_A_CMD, 8'h30);
    rchk(OFS_A_CMD, 8'h00);
    cmd(OFS_A_CMD, 8'h04);
    rchk(OFS_A_CMD, 8'h0C);
    @(posedge mclk iff tick[0]);
    wr(OFS_A_HOLD, 8'h3C);
    rchk(OFS_A_CMD, 8'h00);
    wait_got(300, g);
    chk({g, fbyte}, {1'b1, 8'h3C});
    rchk(OFS_A_CMD, 8'h0C);
  endtask
  task automatic t_brk();
    cmd(OFS_A_CMD, 8'h08);
    cmd(OFS_A_CMD, 8'h60);
    repeat (48) @(posedge mclk);
    #1;
    chk(ser[0], 1'b1);
    cmd(OFS_A_CMD, 8'h04);
    cmd(OFS_A_CMD, 8'h60);
    repeat (48) @(posedge mclk);
    #1;
    chk(ser[0], 1'b0);
    cmd(OFS_A_CMD, 8'h70);
    repeat (40) @(posedge mclk);
    #1;
    chk(ser[0], 1'b1);
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    we = 1'b0;
    re = 1'b0;
    rate_set = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    rx = '0;
    rx_mark = 2'h0;
    mdrop = 2'h0;
    wake = 2'h0;
    par = 2'h0;
    mra = 2'h0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_clk();
    t_enable();
    t_fifo();
    t_break();
    t_misc();
    t_tx();
    t_brk();
    final_report();
  end
endmodule

/* File: tb/ucs_far_model.sv */
// far-side model: bit-time ticks and a receiver on chan a serial line
// assumes ticks every TICK_DIV clocks and the line idles high
`timescale 1ns/1ps
module ucs_far_model #(
  parameter int TICK_DIV = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_line,
  output logic [1:0] o_tick,
  output logic [7:0] o_byte,
  output logic o_got
);
  int div_q;
  int pos_q;
  logic [7:0] sh_q;

  // samples at the tick edge, before the transmitter moves the line
  always_ff @(posedge i_mclk) begin
    o_got <= 1'b0;
    if (!i_rst_b) begin
      div_q <= 0;
      pos_q <= -1;
      o_tick <= 2'h0;
      o_byte <= 8'h00;
      sh_q <= 8'h00;
    end else begin
      div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      o_tick <= {2{div_q == 0}};
      if (o_tick[0]) begin
        if (pos_q < 0) begin
          if (!i_line) pos_q <= 0;
        end else if (pos_q < 8) begin
          sh_q <= {i_line, sh_q[7:1]};
          pos_q <= pos_q + 1;
        end else begin
          // a missing stop bit drops the frame, as a real receiver would
          pos_q <= -1;
          o_got <= i_line;
          o_byte <= sh_q;
        end
      end
    end
  end
endmodule
